// ==== tb/latched_rom_bus_interface_tb.sv ====
// Purpose: Self-checking bench for rom_host against two latched memories
// Assumes: Inputs driven at the falling edge, seed fixed
// Notes: Released data lines are pulled up
`timescale 1ns/1ps
`default_nettype none
module latched_rom_bus_interface_tb;
    logic clk = 1'b0;
    logic rst_b, req_vld, req_rdy, rd_vld, code_src_wr, code_src_val, prog_mode, ser_rx;
    rom_host_pkg::host_req_t req;
    logic [7:0] rd_data, ad_in, ad_out, ad_oe, addr_hi, m_d0, m_d1, mem_bus;
    logic [1:0] latch_sel_n, m_oe;
    logic out_en_n, program_pulse_pin, program_supply_switch_n, external_code_access_n, prog_done;
    logic [7:0] shadow [2][8192];
    int fails = 0, n_compared = 0, dones = 0;
    int falls [2];
    logic [12:0] base;
    logic dv;
    always #5 clk = ~clk;
    rom_host uut (.clk(clk), .rst_b(rst_b), .req_vld(req_vld), .req(req), .req_rdy(req_rdy),
        .rd_vld(rd_vld), .rd_data(rd_data), .code_src_wr(code_src_wr), .code_src_val(code_src_val),
        .prog_mode(prog_mode), .ser_rx(ser_rx), .ser_tx(), .ad_in(ad_in), .ad_out(ad_out),
        .ad_oe(ad_oe), .addr_hi(addr_hi), .latch_sel_n(latch_sel_n), .out_en_n(out_en_n),
        .program_pulse_pin(program_pulse_pin), .program_supply_switch_n(program_supply_switch_n),
        .external_code_access_n(external_code_access_n), .prog_done(prog_done));
    latched_rom_model #(.DEV_ID(0), .ACC_NS(12)) mem0 (.latch_sel_n(latch_sel_n[0]),
        .out_en_n(out_en_n), .program_pulse_pin(program_pulse_pin),
        .program_supply_switch_n(program_supply_switch_n), .addr_hi(addr_hi[4:0]),
        .ad_bus(ad_in), .data_out(m_d0), .data_oe(m_oe[0]));
    latched_rom_model #(.DEV_ID(1), .ACC_NS(28)) mem1 (.latch_sel_n(latch_sel_n[1]),
        .out_en_n(out_en_n), .program_pulse_pin(program_pulse_pin),
        .program_supply_switch_n(program_supply_switch_n), .addr_hi(addr_hi[4:0]),
        .ad_bus(ad_in), .data_out(m_d1), .data_oe(m_oe[1]));
    assign mem_bus = m_oe[0] ? m_d0 : (m_oe[1] ? m_d1 : 8'hff);
    assign ad_in = (ad_oe & ad_out) | (~ad_oe & mem_bus);
    always @(negedge latch_sel_n[0]) falls[0]++;
    always @(negedge latch_sel_n[1]) falls[1]++;
    always @(posedge clk) if (prog_done === 1'b1) dones++;
    // Host and memory must never fight over the shared lines
    always @(posedge clk) begin
        if (rst_b && ((ad_oe != 8'h00 && m_oe != 2'b00) || m_oe == 2'b11)) begin
            fails++;
            $display("[ERR] t=%0t oe=%h mem_oe=%h", $time, ad_oe, m_oe);
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    function automatic logic [7:0] init_val(input int d, input int a);
        return 8'(a ^ (a >> 5) ^ (d * 90));
    endfunction : init_val
    task automatic read_chk(input logic d, input logic [12:0] a);
        int i;
        for (i = 0; i < 50 && req_rdy !== 1'b1; i++) @(negedge clk);
        if (i == 50) begin fails++; test_done(); end
        falls = '{0, 0};
        req_vld = 1'b1;
        req = '{write: 1'b0, addr: {d, a}, data: 8'(base)};
        @(negedge clk);
        req_vld = 1'b0;
        for (i = 1; i < 20 && rd_vld !== 1'b1; i++) @(negedge clk);
        if (i == 20) begin fails++; test_done(); end
        // Address, latch and access phases, plus one for the loop's start value
        check(16'(i), 16'(rom_host_pkg::STROBE_CYC * 2 + rom_host_pkg::ACCESS_CYC + 1));
        check({8'h00, rd_data}, {8'h00, shadow[d][a]});
        check(16'(falls[d]), 16'd1);
        check(16'(falls[!d]), 16'd0);
    endtask : read_chk
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int k = 0; k < 10; k++) begin
            ser_rx = f[k];
            repeat (16) @(negedge clk);
        end
    endtask : send_byte
    task automatic prog_word(input logic d, input logic [12:0] a, input logic [7:0] v);
        int i, n;
        n = dones;
        falls = '{0, 0};
        send_byte({2'b00, d, a[12:8]});
        send_byte(a[7:0]);
        send_byte(v);
        for (i = 0; i < 300 && dones == n; i++) @(negedge clk);
        if (i == 300) begin fails++; test_done(); end
        check(16'(falls[d]), 16'd1);
        shadow[d][a] = shadow[d][a] & v;
    endtask : prog_word
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'he5df));
        rst_b = 1'b0; req_vld = 1'b0; req = '0; code_src_wr = 1'b0;
        code_src_val = 1'b0; prog_mode = 1'b0; ser_rx = 1'b1; base = '0;
        for (int j = 0; j < 8192; j++) begin
            shadow[0][j] = init_val(0, j);
            shadow[1][j] = init_val(1, j);
        end
        repeat (10) @(negedge clk);
        check(16'({latch_sel_n, out_en_n, program_pulse_pin, program_supply_switch_n,
            external_code_access_n, ad_oe}), 16'h3f00);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        for (int k = 0; k < 2; k++) begin
            code_src_wr = 1'b1;
            code_src_val = k[0];
            @(negedge clk);
            code_src_wr = 1'b0;
            repeat (2) @(negedge clk);
            check({15'h0, external_code_access_n}, 16'(k));
        end
        prog_mode = 1'b1;
        repeat (3) @(negedge clk);
        check({14'h0, req_rdy, program_supply_switch_n}, 16'h0000);
        prog_word(1'b0, 13'h0000, 8'($urandom));
        prog_word(1'b1, 13'h1fff, 8'($urandom));
        for (int k = 0; k < 3; k++) prog_word(k[0], 13'($urandom), 8'($urandom));
        prog_mode = 1'b0;
        repeat (4) @(negedge clk);
        check({15'h0, program_supply_switch_n}, 16'h0001);
        read_chk(1'b0, 13'h0000);
        read_chk(1'b1, 13'h1fff);
        read_chk(1'b0, 13'h1fff);
        read_chk(1'b1, 13'h0000);
        for (int k = 0; k < 4; k++) begin
            dv = 1'($urandom);
            base = 13'($urandom_range(8180));
            for (int s = 0; s < 6; s++) read_chk(dv, base + 13'(s));
        end
        for (int k = 0; k < 30; k++) read_chk(1'($urandom), 13'($urandom));
        test_done();
    end
    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        test_done();
    end
endmodule : latched_rom_bus_interface_tb
`default_nettype wire

// ==== tb/latched_rom_model.sv ====
// Purpose: Behavioural latched program memory at the far side of rom_host
// Assumes: Combined latch/select and output enable, both active low
// Notes: Programming only clears bits, as a real cell array does
`timescale 1ns/1ps
`default_nettype none
module latched_rom_model #(
    parameter int DEV_ID = 0,
    parameter int ACC_NS = 15
) (
    // Control pins
    input wire logic latch_sel_n,
    input wire logic out_en_n,
    input wire logic program_pulse_pin,
    input wire logic program_supply_switch_n,
    // Address and data
    input wire logic [4:0] addr_hi,
    input wire logic [7:0] ad_bus,
    output logic [7:0] data_out,
    output logic data_oe
);
    // ----------------------------------------
    // Array, latch and output
    // ----------------------------------------
    logic [7:0] mem [0:8191];
    logic [12:0] addr_q;
    logic [7:0] pend;
    initial begin
        for (int i = 0; i < 8192; i++) begin
            mem[i] = 8'(i ^ (i >> 5) ^ (DEV_ID * 90));
        end
    end
    // Transparent while strobe high, holds from its fall
    always_latch begin
        if (latch_sel_n) begin
            addr_q = {addr_hi, ad_bus};
        end
    end
    // Select high is standby, so nothing is driven then
    assign data_oe = !latch_sel_n && !out_en_n;
    // Slow instances show stale data until the access time runs out
    assign #(ACC_NS) data_out = mem[addr_q];
    // Data taken as the pulse starts; the host may release the bus as it ends
    always @(negedge program_pulse_pin) begin
        pend = ad_bus;
    end
    always @(posedge program_pulse_pin) begin
        if (!latch_sel_n && !program_supply_switch_n) begin
            mem[addr_q] = mem[addr_q] & pend;
        end
    end
endmodule : latched_rom_model
`default_nettype wire

// ==== verilog/rom_host.sv ====
// Purpose: Host controller reading and programming latched program memories
// Assumes: Memory is external; pins synchronous to clk
// Notes: Bus is multiplexed; ad lines shared with memory data pins
`timescale 1ns/1ps
`default_nettype none
module rom_host #(
    parameter int NUM_DEV = rom_host_pkg::NUM_DEV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // User read port
    input wire logic req_vld,
    input wire rom_host_pkg::host_req_t req,
    output logic req_rdy,
    output logic rd_vld,
    output logic [rom_host_pkg::DATA_W-1:0] rd_data,
    // Mode controls
    input wire logic code_src_wr,
    input wire logic code_src_val,
    input wire logic prog_mode,
    // Serial programming channel
    input wire logic ser_rx,
    output logic ser_tx,
    // Multiplexed address/data bus
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic [7:0] ad_oe,
    output logic [7:0] addr_hi,
    // Memory control pins
    output logic [NUM_DEV-1:0] latch_sel_n,
    output logic out_en_n,
    output logic program_pulse_pin,
    output logic program_supply_switch_n,
    output logic external_code_access_n,
    output logic prog_done
);
    rom_host_pkg::host_state_t st_r, st_nxt;
    logic [rom_host_pkg::CNT_W-1:0] cnt_r;
    logic [15:0] addr_r;
    logic [7:0] data_r;
    logic wr_r;
    logic addr_strobe_r;
    logic manual_latch_control_r;
    logic program_pulse_control_r;
    logic code_source_control_r;
    logic ser_vld;
    logic [23:0] ser_word;

    function automatic logic [NUM_DEV-1:0] dev_decode(input logic [15:0] a, input logic strobe);
        logic [NUM_DEV-1:0] d;
        d = '1;
        for (int i = 0; i < NUM_DEV; i++) begin
            if (a[rom_host_pkg::ADDR_W +: rom_host_pkg::SEL_W] == rom_host_pkg::SEL_W'(i)) begin
                d[i] = strobe;
            end
        end
        return d;
    endfunction : dev_decode

    serial_rx u_rx (
        .clk(clk),
        .rst_b(rst_b),
        .rx_pin(ser_rx),
        .word_vld(ser_vld),
        .word(ser_word)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            rom_host_pkg::ST_IDLE: begin
                if (prog_mode && ser_vld) begin
                    st_nxt = rom_host_pkg::ST_ADDR;
                end else if (!prog_mode && req_vld) begin
                    st_nxt = rom_host_pkg::ST_ADDR;
                end
            end
            rom_host_pkg::ST_ADDR: begin
                if (cnt_r == 0) begin
                    st_nxt = rom_host_pkg::ST_LATCH;
                end
            end
            rom_host_pkg::ST_LATCH: begin
                if (cnt_r == 0) begin
                    st_nxt = wr_r ? rom_host_pkg::ST_PSET : rom_host_pkg::ST_READ;
                end
            end
            rom_host_pkg::ST_READ: begin
                if (cnt_r == 0) begin
                    st_nxt = rom_host_pkg::ST_DONE;
                end
            end
            rom_host_pkg::ST_PSET: begin
                if (cnt_r == 0) begin
                    st_nxt = rom_host_pkg::ST_PULSE;
                end
            end
            rom_host_pkg::ST_PULSE: begin
                if (cnt_r == 0) begin
                    st_nxt = rom_host_pkg::ST_DONE;
                end
            end
            rom_host_pkg::ST_DONE: st_nxt = rom_host_pkg::ST_IDLE;
            default: st_nxt = rom_host_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= rom_host_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    function automatic logic [rom_host_pkg::CNT_W-1:0] CNT_W_T(input int v);
        return v[rom_host_pkg::CNT_W-1:0];
    endfunction : CNT_W_T

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (st_nxt != st_r) begin
            case (st_nxt)
                rom_host_pkg::ST_ADDR: cnt_r <= CNT_W_T(rom_host_pkg::STROBE_CYC - 1);
                rom_host_pkg::ST_LATCH: cnt_r <= CNT_W_T(rom_host_pkg::STROBE_CYC - 1);
                rom_host_pkg::ST_READ: cnt_r <= CNT_W_T(rom_host_pkg::ACCESS_CYC - 1);
                rom_host_pkg::ST_PSET: cnt_r <= CNT_W_T(rom_host_pkg::STROBE_CYC - 1);
                rom_host_pkg::ST_PULSE: cnt_r <= CNT_W_T(rom_host_pkg::PULSE_CYC - 1);
                default: cnt_r <= '0;
            endcase
        end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - rom_host_pkg::CNT_W'(1);
        end
    end

    // ----------------------------------------
    // Request capture
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_r <= rom_host_pkg::RST_ADDR;
            data_r <= '0;
            wr_r <= 1'b0;
        end else if (st_r == rom_host_pkg::ST_IDLE && st_nxt == rom_host_pkg::ST_ADDR) begin
            if (prog_mode) begin
                addr_r <= ser_word[23:8];
                data_r <= ser_word[7:0];
                wr_r <= 1'b1;
            end else begin
                addr_r <= 16'(req.addr);
                data_r <= req.data;
                wr_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Strobes: every access starts from strobe high, giving a fresh fall
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_strobe_r <= 1'b1;
            manual_latch_control_r <= 1'b1;
            program_pulse_control_r <= 1'b1;
        end else begin
            addr_strobe_r <= (st_nxt == rom_host_pkg::ST_ADDR) || (st_nxt == rom_host_pkg::ST_IDLE);
            manual_latch_control_r <= !prog_mode || (st_nxt == rom_host_pkg::ST_ADDR)
                || (st_nxt == rom_host_pkg::ST_IDLE);
            program_pulse_control_r <= (st_nxt != rom_host_pkg::ST_PULSE);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_sel_n <= '1;
            program_supply_switch_n <= 1'b1;
            program_pulse_pin <= 1'b1;
        end else begin
            program_supply_switch_n <= !prog_mode;
            program_pulse_pin <= program_pulse_control_r;
            // Low supply switch hands the select to the manual latch line
            if (program_supply_switch_n) begin
                latch_sel_n <= dev_decode(addr_r, addr_strobe_r);
            end else begin
                latch_sel_n <= dev_decode(addr_r, manual_latch_control_r);
            end
        end
    end

    // ----------------------------------------
    // Bus drive and read data
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ad_out <= '0;
            ad_oe <= '0;
            addr_hi <= '0;
            out_en_n <= 1'b1;
        end else begin
            addr_hi <= {3'h0, st_nxt == rom_host_pkg::ST_IDLE ? 5'h00 : addr_r[12:8]};
            out_en_n <= (st_nxt != rom_host_pkg::ST_READ);
            case (st_nxt)
                rom_host_pkg::ST_ADDR, rom_host_pkg::ST_LATCH: begin
                    ad_out <= addr_r[7:0];
                    ad_oe <= '1;
                end
                rom_host_pkg::ST_PSET, rom_host_pkg::ST_PULSE: begin
                    ad_out <= data_r;
                    ad_oe <= '1;
                end
                // Write data stays up until the pulse pin, one flop behind, has risen
                rom_host_pkg::ST_DONE: begin
                    ad_out <= wr_r ? data_r : 8'h00;
                    ad_oe <= {8{wr_r}};
                end
                default: begin
                    ad_out <= '0;
                    ad_oe <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_vld <= 1'b0;
            rd_data <= '0;
            req_rdy <= 1'b0;
            prog_done <= 1'b0;
        end else begin
            rd_vld <= 1'b0;
            prog_done <= 1'b0;
            if (st_r == rom_host_pkg::ST_READ && cnt_r == 0) begin
                rd_vld <= 1'b1;
                rd_data <= ad_in;
            end
            if (st_r == rom_host_pkg::ST_PULSE && cnt_r == 0) begin
                prog_done <= 1'b1;
            end
            req_rdy <= !prog_mode && (st_nxt == rom_host_pkg::ST_IDLE);
        end
    end

    // ----------------------------------------
    // Code source control, high after reset
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            code_source_control_r <= 1'b1;
            external_code_access_n <= 1'b1;
            ser_tx <= 1'b1;
        end else begin
            if (code_src_wr) begin
                code_source_control_r <= code_src_val;
            end
            external_code_access_n <= code_source_control_r;
            ser_tx <= 1'b1;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_fresh_fall;
        @(posedge clk) disable iff (!rst_b)
        (st_r == rom_host_pkg::ST_LATCH && $past(st_r) == rom_host_pkg::ST_ADDR) |-> ##1 !(&latch_sel_n);
    endproperty
    a_fresh_fall: assert property (p_fresh_fall) else $error("no select fall on access");

    property p_idle_standby;
        @(posedge clk) disable iff (!rst_b)
        (st_r == rom_host_pkg::ST_IDLE) [*2] |-> &latch_sel_n;
    endproperty
    a_idle_standby: assert property (p_idle_standby) else $error("select low while idle");

    property p_no_contention;
        @(posedge clk) disable iff (!rst_b)
        !out_en_n |-> ad_oe == 8'h00;
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("host drives bus during read");

    property p_read_done;
        @(posedge clk) disable iff (!rst_b)
        $fell(out_en_n) |-> ##4 rd_vld;
    endproperty
    a_read_done: assert property (p_read_done) else $error("read data not returned");

    property p_addr_before_latch;
        @(posedge clk) disable iff (!rst_b)
        $fell(latch_sel_n[0]) |-> ad_oe == 8'hff;
    endproperty
    a_addr_before_latch: assert property (p_addr_before_latch) else $error("address absent at latch");

    property p_pulse_after_latch;
        @(posedge clk) disable iff (!rst_b)
        $fell(program_pulse_pin) |-> !program_supply_switch_n && !(&latch_sel_n);
    endproperty
    a_pulse_after_latch: assert property (p_pulse_after_latch) else $error("pulse without latch");

    property p_pulse_len;
        @(posedge clk) disable iff (!rst_b)
        $fell(program_pulse_pin) |-> !program_pulse_pin [*5] ##1 program_pulse_pin;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("program pulse wrong length");

    property p_code_src;
        @(posedge clk) disable iff (!rst_b)
        code_src_wr |-> ##2 external_code_access_n == $past(code_src_val, 2);
    endproperty
    a_code_src: assert property (p_code_src) else $error("code source not applied");
endmodule : rom_host
`default_nettype wire

// ==== verilog/rom_host_pkg.sv ====
// Purpose: Constants and types for the latched program memory host controller
// Assumes: 100 MHz clk, synchronous pin inputs
// Notes: Notes on behaviour follow
// Notes on behaviour
// - Host gives select a fresh high-to-low edge for every new address.
// - With several memories, select is upper decode gated by address strobe.
// - In 8-bit systems low address pins tie to data pins and bus.
// - In 16-bit systems bus lines 1..13 give word address, bit 0 unused.
// - Code-source control is high after reset or when written one.
// - Separate host outputs drive manual latch, program pulse, supply switch; here manual latch has no pin of its own and is muxed onto latch_sel_n.
// - Address and data for programming arrive over a two-pin serial channel.
// - Programming: address placed with manual latch high, then latch driven low.
// - Supply switch high routes address strobe, low routes manual latch.
package rom_host_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int NUM_DEV = 2;
    localparam int SEL_W = 1;
    // Phase lengths in cycles
    localparam int STROBE_CYC = 2;
    localparam int ACCESS_CYC = 4;
    localparam int PULSE_CYC = 5;
    localparam int CNT_W = 4;
    localparam int BAUD_DIV = 16;
    localparam int BAUD_W = 5;
    localparam logic [15:0] RST_ADDR = 16'h0000;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ADDR = 7'b000_0010,
        ST_LATCH = 7'b000_0100,
        ST_READ = 7'b000_1000,
        ST_PSET = 7'b001_0000,
        ST_PULSE = 7'b010_0000,
        ST_DONE = 7'b100_0000
    } host_state_t;

    typedef struct packed {
        logic write;
        logic [SEL_W+ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } host_req_t;

    typedef struct packed {
        logic latch_sel_n;
        logic out_en_n;
        logic program_pulse_pin;
    } mem_ctl_t;
endpackage : rom_host_pkg

// ==== verilog/serial_rx.sv ====
// Purpose: Two-pin serial receiver feeding programming words
// Assumes: 8N1 frames, fixed divider, line idles high
// Notes: Collects three bytes: addr high, addr low, data
`timescale 1ns/1ps
`default_nettype none
module serial_rx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Serial pin
    input wire logic rx_pin,
    // Assembled word
    output logic word_vld,
    output logic [23:0] word
);
    logic [rom_host_pkg::BAUD_W-1:0] baud_r;
    logic [3:0] bit_r;
    logic busy_r;
    logic [7:0] sh_r;
    logic [1:0] byte_r;

    // ----------------------------------------
    // Bit timing, sampling mid-bit
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            baud_r <= '0;
            bit_r <= '0;
            busy_r <= 1'b0;
            sh_r <= '0;
        end else if (!busy_r) begin
            if (!rx_pin) begin
                busy_r <= 1'b1;
                baud_r <= 5'(rom_host_pkg::BAUD_DIV / 2);
                bit_r <= '0;
            end
        end else if (baud_r == 0) begin
            baud_r <= 5'(rom_host_pkg::BAUD_DIV - 1);
            bit_r <= bit_r + 4'h1;
            if (bit_r >= 4'h1 && bit_r <= 4'h8) begin
                sh_r <= {rx_pin, sh_r[7:1]};
            end
            if (bit_r == 4'h9) begin
                busy_r <= 1'b0;
            end
        end else begin
            baud_r <= baud_r - 5'h01;
        end
    end

    // ----------------------------------------
    // Byte assembly
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            byte_r <= '0;
            word <= '0;
            word_vld <= 1'b0;
        end else begin
            word_vld <= 1'b0;
            if (busy_r && baud_r == 0 && bit_r == 4'h9) begin
                word <= {word[15:0], sh_r};
                if (byte_r == 2'h2) begin
                    byte_r <= '0;
                    word_vld <= 1'b1;
                end else begin
                    byte_r <= byte_r + 2'h1;
                end
            end
        end
    end
endmodule : serial_rx
`default_nettype wire
